// File: src/rss_relay_sequencer.sv
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module rss_relay_sequencer #(
    parameter int TICK_CYCLES = rss_pkg::TICK_CYC
) (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // Front panel button level, asynchronous.
    input  wire logic        button_any,
    // Avalon-MM slave.
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Relay drivers: sense_close and exc_close have one bit per channel, bit 0 is channel 1; bypass_on and buffer_on are single bits.
    output logic [7:0]       sense_close,
    output logic [7:0]       exc_close,
    output logic             bypass_on,
    output logic             buffer_on
);
    initial
    begin
        if (TICK_CYCLES < 2)
            $error("TICK_CYCLES too small");
    end

    // Button synchroniser.
    logic btn_s1_r;
    logic btn_s2_r;
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            btn_s1_r <= 1'b0;
            btn_s2_r <= 1'b0;
        end
        else
        begin
            btn_s1_r <= button_any;
            btn_s2_r <= btn_s1_r;
        end
    end

    // Configuration state, the stored image, and the sequencer.
    rss_pkg::rss_state_e st_r, st_nxt;
    logic [3:0] channel_select_command_r, channel_select_command_nxt;     // Target channel.
    logic [3:0] old_r, old_nxt;       // Channel being left.
    logic [3:0] pend_ch_r, pend_ch_nxt;
    logic       pend_r, pend_nxt;
    logic       byp_r, byp_nxt;
    logic       buf_r, buf_nxt;
    logic       ord_r, ord_nxt;
    logic       boot_r, boot_nxt;     // Power-on load still to do.
    logic [1:0] bwait_r, bwait_nxt;   // Lets the button synchroniser settle first.
    logic [3:0] nv_ch_r, nv_ch_nxt;
    logic       nv_byp_r, nv_byp_nxt;
    logic       nv_buf_r, nv_buf_nxt;
    logic       nv_ord_r, nv_ord_nxt;
    logic       nv_ok_r, nv_ok_nxt;
    logic [7:0] sen_r, sen_nxt;
    logic [7:0] exc_r, exc_nxt;
    logic       t_start;
    logic [3:0] t_load;
    logic       t_done;

    // One-hot lead pattern for a channel code; none gives zero.
    function automatic logic [7:0] onehot(input logic [3:0] ch);
        logic [7:0] v;
        v = 8'h00;
        if (ch != rss_pkg::CH_NONE && ch <= 4'(rss_pkg::NUM_CH))
            v[3'(ch - 4'h1)] = 1'b1;
        return v;
    endfunction

    logic wr_ctrl, wr_cmd, wr_nv;
    logic [3:0] req_ch;
    logic req_go;
    // A write acts only at the edge that ends its wait state, so it acts once.
    assign wr_ctrl = avs_write && !avs_waitrequest && avs_address == rss_pkg::OFF_CTRL;
    assign wr_cmd  = avs_write && !avs_waitrequest && avs_address == rss_pkg::OFF_CMD;
    assign wr_nv   = avs_write && !avs_waitrequest && avs_address == rss_pkg::OFF_NV;

    rss_ms_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .start   (t_start),
        .ms_load (t_load),
        .done    (t_done)
    );

    // Next-state logic for configuration and relay sequencing.
    always_comb
    begin
        st_nxt = st_r; channel_select_command_nxt = channel_select_command_r; old_nxt = old_r;
        pend_nxt = pend_r; pend_ch_nxt = pend_ch_r;
        byp_nxt = byp_r; buf_nxt = buf_r; ord_nxt = ord_r;
        boot_nxt = boot_r && bwait_r != 2'h0;
        bwait_nxt = (bwait_r != 2'h0) ? bwait_r - 2'h1 : 2'h0;
        nv_ch_nxt = nv_ch_r; nv_byp_nxt = nv_byp_r;
        nv_buf_nxt = nv_buf_r; nv_ord_nxt = nv_ord_r; nv_ok_nxt = nv_ok_r;
        sen_nxt = sen_r; exc_nxt = exc_r;
        t_start = 1'b0;
        t_load = 4'(rss_pkg::STEP_MS);
        req_go = 1'b0;
        req_ch = rss_pkg::DEF_CHANNEL_SELECT_COMMAND;
        // Stored image written by the storage controller.
        if (wr_nv)
        begin
            nv_ch_nxt  = avs_writedata[rss_pkg::F_CHANNEL_SELECT_COMMAND +: 4];
            nv_byp_nxt = avs_writedata[rss_pkg::F_BYP];
            nv_buf_nxt = avs_writedata[rss_pkg::F_BUF];
            nv_ord_nxt = avs_writedata[rss_pkg::F_ORD];
            nv_ok_nxt  = avs_writedata[rss_pkg::F_NV_VALID];
        end
        if (boot_r && bwait_r == 2'h0)
        begin
            if (btn_s2_r || !nv_ok_r)
            begin
                req_ch = rss_pkg::DEF_CHANNEL_SELECT_COMMAND;
            end
            else
            begin
                req_ch = nv_ch_r;
                byp_nxt = nv_byp_r;
                buf_nxt = nv_buf_r;
                ord_nxt = nv_ord_r;
            end
            req_go = 1'b1;
        end
        else if (wr_cmd && avs_writedata[rss_pkg::F_CMD_RST])
        begin
            byp_nxt = rss_pkg::DEF_BYPASS;
            buf_nxt = rss_pkg::DEF_BUFFER;
            ord_nxt = rss_pkg::DEF_ORDER;
            req_ch = rss_pkg::DEF_CHANNEL_SELECT_COMMAND;
            req_go = 1'b1;
        end
        else if (wr_ctrl)
        begin
            byp_nxt = avs_writedata[rss_pkg::F_BYP];
            buf_nxt = avs_writedata[rss_pkg::F_BUF];
            ord_nxt = avs_writedata[rss_pkg::F_ORD];
            req_ch = avs_writedata[rss_pkg::F_CHANNEL_SELECT_COMMAND +: 4];
            req_go = 1'b1;
        end
        if (wr_cmd && avs_writedata[rss_pkg::F_CMD_SAVE])
        begin
            nv_ch_nxt = channel_select_command_r; nv_byp_nxt = byp_r;
            nv_buf_nxt = buf_r; nv_ord_nxt = ord_r; nv_ok_nxt = 1'b1;
        end
        // Requests during a sequence wait; the newest one wins.
        if (req_go && req_ch > 4'(rss_pkg::NUM_CH))
            req_go = 1'b0;
        if (req_go)
        begin
            pend_nxt = 1'b1;
            pend_ch_nxt = req_ch;
        end
        case (st_r)
            rss_pkg::RSS_IDLE:
            begin
                if (pend_r && !req_go)
                begin
                    pend_nxt = 1'b0;
                    if (pend_ch_r != channel_select_command_r)
                    begin
                        old_nxt = channel_select_command_r;
                        channel_select_command_nxt = pend_ch_r;
                        if (channel_select_command_r == rss_pkg::CH_NONE)
                        begin
                            sen_nxt = onehot(pend_ch_r);
                            exc_nxt = onehot(pend_ch_r);
                        end
                        else if (ord_r == rss_pkg::ORDER_BBM)
                        begin
                            sen_nxt = 8'h00;
                            exc_nxt = 8'h00;
                            if (pend_ch_r != rss_pkg::CH_NONE)
                            begin
                                t_start = 1'b1;
                                st_nxt = rss_pkg::RSS_MAKE;
                            end
                        end
                        else
                        begin
                            sen_nxt = 8'h00;
                            t_start = 1'b1;
                            st_nxt = (pend_ch_r == rss_pkg::CH_NONE) ?
                                rss_pkg::RSS_EXC_OFF : rss_pkg::RSS_MAKE;
                        end
                    end
                end
            end
            rss_pkg::RSS_MAKE:
            begin
                if (t_done)
                begin
                    sen_nxt = onehot(channel_select_command_r);
                    exc_nxt = exc_r | onehot(channel_select_command_r);
                    if (ord_r == rss_pkg::ORDER_MBB)
                    begin
                        t_start = 1'b1;
                        st_nxt = rss_pkg::RSS_EXC_OFF;
                    end
                    else
                        st_nxt = rss_pkg::RSS_IDLE;
                end
            end
            rss_pkg::RSS_EXC_OFF:
            begin
                if (t_done)
                begin
                    exc_nxt = onehot(channel_select_command_r);
                    st_nxt = rss_pkg::RSS_IDLE;
                end
            end
            default:
                st_nxt = rss_pkg::RSS_IDLE;
        endcase
        // Sequence order is latched at its start by holding mode changes.
        if (st_r != rss_pkg::RSS_IDLE && !boot_r)
            ord_nxt = ord_r;
    end

    // Registers only; relays start open with defaults until boot load.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r <= rss_pkg::RSS_IDLE;
            channel_select_command_r <= rss_pkg::DEF_CHANNEL_SELECT_COMMAND; old_r <= rss_pkg::DEF_CHANNEL_SELECT_COMMAND;
            pend_r <= 1'b0; pend_ch_r <= rss_pkg::DEF_CHANNEL_SELECT_COMMAND;
            byp_r <= rss_pkg::DEF_BYPASS; buf_r <= rss_pkg::DEF_BUFFER;
            ord_r <= rss_pkg::DEF_ORDER;
            boot_r <= 1'b1;
            bwait_r <= 2'h2;
            nv_ch_r <= rss_pkg::DEF_CHANNEL_SELECT_COMMAND; nv_byp_r <= 1'b0;
            nv_buf_r <= 1'b0; nv_ord_r <= 1'b0; nv_ok_r <= 1'b0;
            sen_r <= 8'h00; exc_r <= 8'h00;
        end
        else
        begin
            st_r <= st_nxt; channel_select_command_r <= channel_select_command_nxt; old_r <= old_nxt;
            pend_r <= pend_nxt; pend_ch_r <= pend_ch_nxt;
            byp_r <= byp_nxt; buf_r <= buf_nxt; ord_r <= ord_nxt;
            boot_r <= boot_nxt;
            bwait_r <= bwait_nxt;
            nv_ch_r <= nv_ch_nxt; nv_byp_r <= nv_byp_nxt;
            nv_buf_r <= nv_buf_nxt; nv_ord_r <= nv_ord_nxt; nv_ok_r <= nv_ok_nxt;
            sen_r <= sen_nxt; exc_r <= exc_nxt;
        end
    end

    // Read data registered; every access answers one cycle after it begins.
    logic [31:0] rd_r, rd_nxt;
    logic        ack_r, ack_nxt;
    always_comb
    begin
        ack_nxt = (avs_read || avs_write) && !ack_r;
        rd_nxt = rd_r;
        if (avs_read && !ack_r)
        begin
            case (avs_address)
                rss_pkg::OFF_CTRL:
                    rd_nxt = {25'h0, ord_r, buf_r, byp_r, channel_select_command_r};
                rss_pkg::OFF_STAT:
                    rd_nxt = {22'h0, pend_r, st_r != rss_pkg::RSS_IDLE, old_r, channel_select_command_r};
                rss_pkg::OFF_NV:
                    rd_nxt = {23'h0, nv_ok_r, 1'b0, nv_ord_r, nv_buf_r, nv_byp_r, nv_ch_r};
                default:
                    rd_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_r <= 32'h0;
            ack_r <= 1'b0;
        end
        else
        begin
            rd_r <= rd_nxt;
            ack_r <= ack_nxt;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
    assign avs_readdata = rd_r;
    assign sense_close = sen_r;
    assign exc_close = exc_r;
    assign bypass_on = byp_r;
    assign buffer_on = buf_r;

    // Checks.
    property p_sense_break_first;
        @(posedge clk_sys) disable iff (!arst_n)
        (st_r == rss_pkg::RSS_MAKE) |-> sen_r == 8'h00;
    endproperty
    a_sense_break_first: assert property (p_sense_break_first) else $error("sense not open");
    property p_bbm_break;
        @(posedge clk_sys) disable iff (!arst_n)
        (st_r == rss_pkg::RSS_MAKE && ord_r == rss_pkg::ORDER_BBM) |-> exc_r == 8'h00;
    endproperty
    a_bbm_break: assert property (p_bbm_break) else $error("bbm excitation closed");
    property p_mbb_hold;
        @(posedge clk_sys) disable iff (!arst_n)
        (st_r == rss_pkg::RSS_MAKE && ord_r == rss_pkg::ORDER_MBB) |-> exc_r == onehot(old_r);
    endproperty
    a_mbb_hold: assert property (p_mbb_hold) else $error("mbb excitation moved");
    // Cycles spent waiting to make; a counter, since the step is far too long for a delay.
    logic [31:0] mk_cnt_r;
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            mk_cnt_r <= 32'h0;
        else if (st_r == rss_pkg::RSS_MAKE)
            mk_cnt_r <= mk_cnt_r + 32'h1;
        else
            mk_cnt_r <= 32'h0;
    end
    property p_make_step;
        @(posedge clk_sys) disable iff (!arst_n)
        (st_r == rss_pkg::RSS_MAKE && t_done) |->
            mk_cnt_r >= 32'((rss_pkg::STEP_MS - 1) * TICK_CYCLES) &&
            mk_cnt_r <= 32'(rss_pkg::STEP_MS * TICK_CYCLES + 2);
    endproperty
    a_make_step: assert property (p_make_step) else $error("make not at 5 ms");
    property p_exc_off;
        @(posedge clk_sys) disable iff (!arst_n)
        (st_r == rss_pkg::RSS_EXC_OFF && t_done) |=> exc_r == onehot(channel_select_command_r);
    endproperty
    a_exc_off: assert property (p_exc_off) else $error("old excitation stays");
    property p_mbb_make;
        @(posedge clk_sys) disable iff (!arst_n)
        (st_r == rss_pkg::RSS_MAKE && t_done && ord_r) |=> st_r == rss_pkg::RSS_EXC_OFF;
    endproperty
    a_mbb_make: assert property (p_mbb_make) else $error("mbb skipped stage");
    property p_remote_rst;
        @(posedge clk_sys) disable iff (!arst_n)
        (wr_cmd && avs_writedata[rss_pkg::F_CMD_RST] && !boot_r) |=> !byp_r && !buf_r && !ord_r;
    endproperty
    a_remote_rst: assert property (p_remote_rst) else $error("reset defaults");
    property p_held;
        @(posedge clk_sys) disable iff (!arst_n)
        (st_r != rss_pkg::RSS_IDLE) |=> $stable(channel_select_command_r) || $past(st_r) == rss_pkg::RSS_IDLE;
    endproperty
    a_held: assert property (p_held) else $error("channel changed mid sequence");
    c_bbm: cover property (@(posedge clk_sys) st_r == rss_pkg::RSS_MAKE && !ord_r);
    c_mbb: cover property (@(posedge clk_sys) st_r == rss_pkg::RSS_EXC_OFF && channel_select_command_r != 4'h0);
    c_none: cover property (@(posedge clk_sys) st_r == rss_pkg::RSS_EXC_OFF && channel_select_command_r == 4'h0);
endmodule // rss_relay_sequencer
`default_nettype wire

// File: src/rss_pkg.sv
package rss_pkg;
    // Channel code width; code 0 means no channel selected.
    localparam int CH_W = 4;
    localparam int NUM_CH = 8;
    localparam logic [3:0] CH_NONE = 4'h0;
    // Switching order encoding.
    localparam logic ORDER_BBM = 1'b0;
    localparam logic ORDER_MBB = 1'b1;
    // Defaults.
    localparam logic [3:0] DEF_CHANNEL_SELECT_COMMAND = 4'h0;
    localparam logic DEF_BYPASS = 1'b0;
    localparam logic DEF_BUFFER = 1'b0;
    localparam logic DEF_ORDER = 1'b0;
    // Timing.
    localparam int CLK_HZ = 125000000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int STEP_MS = 5;
    // Avalon register offsets (byte addresses).
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_CMD = 4'h4;
    localparam logic [3:0] OFF_STAT = 4'h8;
    localparam logic [3:0] OFF_NV = 4'hc;
    // Field positions.
    localparam int F_CHANNEL_SELECT_COMMAND = 0;
    localparam int F_BYP = 4;
    localparam int F_BUF = 5;
    localparam int F_ORD = 6;
    localparam int F_BUSY = 8;
    localparam int F_PEND = 9;
    localparam int F_CMD_CHANNEL_SELECT_COMMAND = 0;
    localparam int F_CMD_RST = 1;
    localparam int F_CMD_SAVE = 2;
    localparam int F_NV_VALID = 8;
    // Sequencer states.
    typedef enum logic [2:0] {
        RSS_IDLE, RSS_BREAK, RSS_MAKE, RSS_EXC_OFF
    } rss_state_e;
endpackage

// File: src/rss_ms_timer.sv
`timescale 1ns/10ps
`default_nettype none
// Millisecond tick generator with a step countdown measured in ticks.
module rss_ms_timer #(
    parameter int TICK_CYCLES = rss_pkg::TICK_CYC
) (
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    // Control.
    input  wire logic       start,
    input  wire logic [3:0] ms_load,
    // Status.
    output logic            done
);
    initial
    begin
        if (TICK_CYCLES < 2)
            $error("TICK_CYCLES too small");
    end

    logic [31:0] pre_r;
    logic [31:0] pre_nxt;
    logic [3:0]  ms_r;
    logic [3:0]  ms_nxt;
    logic        done_r;
    logic        done_nxt;

    // A restart realigns the prescaler so each step lasts whole milliseconds.
    always_comb
    begin
        pre_nxt  = pre_r;
        ms_nxt   = ms_r;
        done_nxt = 1'b0;
        if (start)
        begin
            pre_nxt = 32'h0;
            ms_nxt  = ms_load;
        end
        else if (ms_r != 4'h0)
        begin
            if (pre_r == 32'(TICK_CYCLES - 1))
            begin
                pre_nxt = 32'h0;
                ms_nxt  = ms_r - 4'h1;
                done_nxt = (ms_r == 4'h1);
            end
            else
                pre_nxt = pre_r + 32'h1;
        end
    end

    // Registers only.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pre_r  <= 32'h0;
            ms_r   <= 4'h0;
            done_r <= 1'b0;
        end
        else
        begin
            pre_r  <= pre_nxt;
            ms_r   <= ms_nxt;
            done_r <= done_nxt;
        end
    end

    assign done = done_r;
endmodule // rss_ms_timer
`default_nettype wire

// File: sim/rss_relay_model.sv
`timescale 1ns/10ps
`default_nettype none
// Relay bank behind the sequencer. Contacts follow the coil drive one clock late
// and have no reset of their own, so they open one clock after a reset clears the drive.
module rss_relay_model (
    // Clock.
    input  wire logic       clk_sys,
    // Coil drives from the sequencer.
    input  wire logic [7:0] sense_close,
    input  wire logic [7:0] exc_close,
    // Contact states at the leads.
    output logic      [7:0] sense_contact,
    output logic      [7:0] exc_contact,
    output logic            fault
);
    logic [7:0] s_r = 8'h00;
    logic [7:0] e_r = 8'h00;
    logic       f_r = 1'b0;

    // Both leads of a pair hang on one coil bit, so a pair always moves in one cycle.
    always @(posedge clk_sys)
    begin
        s_r <= sense_close;
        e_r <= exc_close;
        // Two sense channels closed at once would short the sense inputs together.
        if ($countones(sense_close) > 1)
        begin
            f_r <= 1'b1;
        end
    end

    assign sense_contact = s_r;
    assign exc_contact   = e_r;
    assign fault         = f_r;
endmodule // rss_relay_model
`default_nettype wire

// File: sim/tb_rss_relay_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module tb_rss_relay_sequencer;
    // A short tick keeps each 5 ms step at fifty cycles.
    localparam int TICK = 10;
    localparam int STEP = rss_pkg::STEP_MS * TICK;
    logic        clk_sys = 1'b0;
    logic        arst_n = 1'b0;
    logic        button_any = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [7:0]  sense_close;
    logic [7:0]  exc_close;
    logic        bypass_on;
    logic        buffer_on;
    logic [7:0]  s_ct;
    logic [7:0]  e_ct;
    logic        fault;
    int          err_total = 0;
    int          checks_done = 0;
    int          cycles = 0;
    logic [31:0] seed = 32'h51ed242e;
    logic [31:0] rd;
    logic [3:0]  cur_ch = 4'h0;
    logic [3:0]  tch [6] = '{4'h3, 4'h5, 4'h0, 4'h2, 4'h7, 4'h0};
    logic        tord [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

    rss_relay_sequencer #(.TICK_CYCLES(TICK)) u_rss_relay_sequencer (
        .clk_sys(clk_sys), .arst_n(arst_n), .button_any(button_any),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sense_close(sense_close),
        .exc_close(exc_close), .bypass_on(bypass_on), .buffer_on(buffer_on));

    rss_relay_model u_rss_relay_model (
        .clk_sys(clk_sys), .sense_close(sense_close), .exc_close(exc_close),
        .sense_contact(s_ct), .exc_contact(e_ct), .fault(fault));

    always #4 clk_sys = ~clk_sys;

    // A hung wait must not run forever; the ceiling is well above the expected run.
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            err_total++;
            give_verdict();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [7:0] msk(input logic [3:0] ch);
        return (ch == 4'h0) ? 8'h00 : (8'h01 << (ch - 4'h1));
    endfunction

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
        begin
            $display("ALL CHECKS OK");
        end
        else
        begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask

    // One Avalon transfer; waitrequest is sampled at each rising edge, and the
    // request is released only after the edge at which it is seen low.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50)
            err_total++;
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wait_idle();
        int k;
        k = 0;
        do
        begin
            bus(1'b0, rss_pkg::OFF_STAT, 32'h0);
            k++;
        end
        while ((rd[rss_pkg::F_BUSY] | rd[rss_pkg::F_PEND]) !== 1'b0 && k < 500);
    endtask

    // Counts cycles until the chosen contact group leaves the given value.
    task automatic wt(input logic exc, input logic [7:0] v, output int n);
        n = 0;
        do
        begin
            @(negedge clk_sys);
            n++;
        end
        while ((exc ? e_ct : s_ct) === v && n < 300);
    endtask

    task automatic rng(input int n);
        chk(32'(n >= STEP - TICK && n <= STEP + TICK + 2), 32'h1);
    endtask

    // Sets the order, then moves to a new channel and follows each staged step.
    task automatic do_switch(input logic [3:0] nc, input logic ord);
        logic [7:0] om;
        logic [7:0] nm;
        int n;
        om = msk(cur_ch);
        nm = msk(nc);
        if (nc != cur_ch)
        begin
            bus(1'b1, rss_pkg::OFF_CTRL, {25'h0, ord, 2'b00, cur_ch});
            wait_idle();
            bus(1'b1, rss_pkg::OFF_CTRL, {25'h0, ord, 2'b00, nc});
            wt(1'b0, om, n);
            if (om == 8'h00)
            begin
                chk(32'({s_ct, e_ct}), 32'({nm, nm}));
            end
            else if (ord == rss_pkg::ORDER_BBM)
            begin
                chk(32'({s_ct, e_ct}), 32'h0);
                if (nm != 8'h00)
                begin
                    wt(1'b0, 8'h00, n);
                    rng(n);
                    chk(32'({s_ct, e_ct}), 32'({nm, nm}));
                end
            end
            else
            begin
                chk(32'({s_ct, e_ct}), 32'({8'h00, om}));
                wt(nm == 8'h00, nm == 8'h00 ? om : 8'h00, n);
                rng(n);
                chk(32'({s_ct, e_ct}), 32'({nm, (nm == 8'h00) ? 8'h00 : (om | nm)}));
                if (nm != 8'h00)
                begin
                    wt(1'b1, om | nm, n);
                    rng(n);
                    chk(32'(e_ct), 32'(nm));
                end
            end
            cur_ch = nc;
            wait_idle();
        end
    endtask

    initial
    begin
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        wait_idle();
        bus(1'b0, rss_pkg::OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        chk(32'({bypass_on, buffer_on, sense_close, exc_close}), 32'h0);
        $display("test defaults done");
        bus(1'b1, rss_pkg::OFF_CTRL, 32'h0000_0033);
        wait_idle();
        chk(32'({bypass_on, buffer_on, s_ct}), 32'h304);
        bus(1'b1, rss_pkg::OFF_CMD, 32'h0000_0002);
        wait_idle();
        bus(1'b0, rss_pkg::OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        chk(32'({bypass_on, buffer_on, sense_close, exc_close}), 32'h0);
        $display("test remote reset done");
        for (int i = 0; i < 6; i++)
        begin
            do_switch(tch[i], tord[i]);
        end
        $display("test corner switches done");
        for (int i = 0; i < 12; i++)
        begin
            seed = xs(seed);
            do_switch(4'(seed % 9), seed[16]);
        end
        $display("test random switches done");
        do_switch(4'h0, rss_pkg::ORDER_BBM);
        bus(1'b1, rss_pkg::OFF_CTRL, 32'h0000_0001);
        bus(1'b1, rss_pkg::OFF_CTRL, 32'h0000_0006);
        wait_idle();
        chk(32'(rd[3:0]), 32'h6);
        chk(32'({s_ct, e_ct}), 32'h2020);
        $display("test queued request done");
        bus(1'b1, rss_pkg::OFF_CTRL, 32'h0000_0056);
        wait_idle();
        bus(1'b1, rss_pkg::OFF_CMD, 32'h0000_0004);
        bus(1'b0, rss_pkg::OFF_NV, 32'h0);
        chk(rd, 32'h0000_0156);
        $display("test stored image done");
        @(posedge clk_sys);
        button_any <= 1'b1;
        arst_n <= 1'b0;
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        wait_idle();
        button_any <= 1'b0;
        bus(1'b0, rss_pkg::OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        chk(32'({bypass_on, buffer_on, sense_close, exc_close}), 32'h0);
        chk(32'(fault), 32'h0);
        $display("test button reset done");
        give_verdict();
    end
endmodule // tb_rss_relay_sequencer
`default_nettype wire
